// >>> common/dlp_pkg.sv
package dlp_pkg;
	// Channel count and code width of the default part.
	localparam int CHANNELS  = 2;
	localparam int CODE_W    = 12;
	// Power-down select encodings.
	localparam logic [1:0] PD_NORMAL = 2'h0;
	localparam logic [1:0] PD_1K     = 2'h1;
	localparam logic [1:0] PD_100K   = 2'h2;
	localparam logic [1:0] PD_OPEN   = 2'h3;
	// Reference select encodings.
	localparam logic [1:0] REF_VDD   = 2'h0;
	localparam logic [1:0] REF_BG    = 2'h1;
	// Reset values.
	localparam logic [11:0] CODE_RST = 12'h7ff;
	localparam logic [1:0]  REF_RST  = 2'h0;
	// Power-down entry and exit delays in ns and as cycles of the 50 MHz clock.
	localparam int CLK_NS         = 20;
	localparam int PD_ENTRY_NS    = 10000;
	localparam int PD_EXIT_NS     = 10000;
	localparam int PD_ENTRY_CYC   = (PD_ENTRY_NS + CLK_NS - 1) / CLK_NS;
	localparam int PD_EXIT_CYC    = (PD_EXIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int DLY_W          = 10;
	// Command codes presented by the serial front end.
	typedef enum logic [2:0]
	{
		CMD_NONE,
		CMD_WRITE,
		CMD_WRITE_HV,
		CMD_READ,
		CMD_READ_HV,
		CMD_GC_RESET,
		CMD_GC_WAKE
	} dlp_cmd_t;
endpackage

// >>> common/dlp_chan_if.sv
`timescale 1ns/1ps
// Per-channel control between the top and each channel's output sequencer.
interface dlp_chan_if;
	logic       rst;
	logic [1:0] pdSel;
	logic       drive;
	logic [1:0] pullSel;
	logic       ampOn;
	modport top (output rst, output pdSel, input drive, input pullSel, input ampOn);
	modport seq (input rst, input pdSel, output drive, output pullSel, output ampOn);
endinterface

// >>> hw/dlp_pd_seq.sv
`timescale 1ns/1ps
// Sequences one channel's output stage through power-down entry and exit.
module dlp_pd_seq
	import dlp_pkg::*;
#(
	parameter int ENTRY_CYC = PD_ENTRY_CYC,
	parameter int EXIT_CYC  = PD_EXIT_CYC
)(
	input  wire logic clk_sys,
	dlp_chan_if.seq   ch
);
	typedef enum {S_ON, S_ENTER, S_OFF, S_EXIT} dlp_seq_t;
	dlp_seq_t         state;
	logic [DLY_W-1:0] cnt;
	logic             wantOff;

	assign wantOff = (ch.pdSel != PD_NORMAL);

	// Delay counter and state; a reversed request drops back at once to the state it came from, with no delay.
	always_ff @(posedge clk_sys)
	begin
		if (ch.rst)
		begin
			state <= S_ON;
			cnt   <= '0;
		end
		else
		begin
			case (state)
				S_ON:
				begin
					cnt <= '0;
					if (wantOff)
						state <= S_ENTER; // see [R10]
				end
				S_ENTER:
				begin
					if (!wantOff)
						state <= S_ON;
					else if (cnt == DLY_W'(ENTRY_CYC - 1))
					begin
						state <= S_OFF; // see [R10]
						cnt   <= '0;
					end
					else
						cnt <= cnt + 1'b1;
				end
				S_OFF:
				begin
					cnt <= '0;
					if (!wantOff)
						state <= S_EXIT; // see [R16]
				end
				S_EXIT:
				begin
					if (wantOff)
					begin
						state <= S_OFF;
						cnt   <= '0;
					end
					else if (cnt == DLY_W'(EXIT_CYC - 1))
					begin
						state <= S_ON; // see [R15]
						cnt   <= '0;
					end
					else
						cnt <= cnt + 1'b1;
				end
				default: state <= S_ON;
			endcase
		end
	end

	// Amplifier and ladder power; re-enabled at exit start so settling from zero begins.
	always_comb
	begin
		ch.ampOn   = (state == S_ON) || (state == S_ENTER) || (state == S_EXIT); // see [R9]
		ch.drive   = (state == S_ON) || (state == S_ENTER); // see [R16]
		ch.pullSel = (state == S_OFF) ? ch.pdSel : PD_NORMAL; // see [R7]
	end
endmodule

// >>> hw/dlp_dac_ctrl.sv
`timescale 1ns/1ps
// Operation
// [R1] Latch input high blocks register-to-wiper copies; registers still accept writes.
// [R2] Latch input low copies each code register into its wiper.
// [R3] Loading is level sensitive; held low, wiper follows each write.
// [R4] Latch input is asynchronous to serial activity and is synchronised.
// [R5] All channels on one latch load together when it goes low.
// [R6] Systems without synchronised updates should tie the latch low.
// [R7] Power-down codes: 00 normal, 01 1k, 10 100k, 11 open.
// [R8] Each channel has its own power-down select field.
// [R9] Power-down disables amplifier and ladder, keeps code and configuration.
// [R10] Drive released and pull-down engaged only after the entry delay.
// [R11] Reset forces every power-down field to normal; otherwise commands only.
// [R12] Only write, read, general-call reset and wake-up update the field.
// [R13] Command handling stays active in every power-down mode.
// [R14] Write with 00, general-call wake-up or reset leaves power-down.
// [R15] Leaving power-down re-enables circuits, removes pull-down, drives code.
// [R16] Active drive starts only after the exit delay.
// [R17] General-call reset restores power-on defaults without the reset delay.
// [R18] Gain of two refused when the supply is the reference.
// [R19] General-call wake-up brings every channel out of power-down.
// [R20] Blocked wipers hold their last value.
module dlp_dac_ctrl
	import dlp_pkg::*;
#(
	parameter int NCH       = dlp_pkg::CHANNELS,
	parameter int CW        = dlp_pkg::CODE_W,
	parameter int ENTRY_CYC = dlp_pkg::PD_ENTRY_CYC,
	parameter int EXIT_CYC  = dlp_pkg::PD_EXIT_CYC
)(
	input  wire logic                clk_sys,
	input  wire logic                srst,
	input  wire logic                update_hold_n,
	input  wire dlp_pkg::dlp_cmd_t   cmd,
	input  wire logic [NCH-1:0]      cmdChanMask,
	input  wire logic                cmdCodeValid,
	input  wire logic [CW-1:0]       cmdCode,
	input  wire logic                cmdPdValid,
	input  wire logic [1:0]          cmdPd,
	input  wire logic                cmdCfgValid,
	input  wire logic [1:0]          cmdRef,
	input  wire logic                cmdGain,
	output logic [NCH*CW-1:0]        codeReg,
	output logic [NCH*CW-1:0]        wiper,
	output logic [NCH*2-1:0]         powerdown_select,
	output logic [NCH*2-1:0]         reference_select,
	output logic [NCH-1:0]           gain_select,
	output logic [NCH-1:0]           ampEnable,
	output logic [NCH-1:0]           outDrive,
	output logic [NCH*2-1:0]         pullSelect,
	output logic                     latchLevel
);
	import dlp_pkg::*;

	logic [2:0]   holdSync;
	logic         latchOpen;
	logic         anyReset;
	logic [NCH-1:0] seqDrive;
	logic [NCH-1:0] seqAmp;
	logic [NCH*2-1:0] seqPull;

	// Returns true for commands that may carry a power-down field.
	function automatic logic pdCommand(input dlp_cmd_t c);
		pdCommand = (c == CMD_WRITE) || (c == CMD_WRITE_HV) || (c == CMD_READ) || (c == CMD_READ_HV);
	endfunction

	// Returns true for register writes.
	function automatic logic wrCommand(input dlp_cmd_t c);
		wrCommand = (c == CMD_WRITE) || (c == CMD_WRITE_HV);
	endfunction

	// General-call reset acts as a power-on reset minus the reset delay timer.
	assign anyReset = srst || (cmd == CMD_GC_RESET); // see [R17]

	// The latch pin passes three flops; a change counts once stages two and three agree.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			holdSync <= 3'h7;
		else
			holdSync <= {holdSync[1:0], update_hold_n}; // see [R4]
	end

	// Level filter; the first stage is never looked at directly.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			latchOpen <= 1'b0;
		else if (holdSync[1] == holdSync[2])
			latchOpen <= ~holdSync[1];
	end

	generate
		for (genvar i = 0; i < NCH; i++)
		begin : g_ch
			dlp_chan_if chIf ();

			// Code register accepts writes regardless of the latch level.
			always_ff @(posedge clk_sys)
			begin
				if (anyReset)
					codeReg[i*CW +: CW] <= CW'(CODE_RST);
				else if (wrCommand(cmd) && cmdChanMask[i] && cmdCodeValid)
					codeReg[i*CW +: CW] <= cmdCode; // see [R1]
			end

			// Wiper follows the register while open, holds while blocked; all channels share one latch.
			always_ff @(posedge clk_sys)
			begin
				if (anyReset)
					wiper[i*CW +: CW] <= CW'(CODE_RST);
				else if (latchOpen)
					wiper[i*CW +: CW] <= codeReg[i*CW +: CW]; // see [R2] see [R3] see [R5]
			end // Otherwise held. see [R20]

			// Per-channel power-down field, changed only by the listed commands.
			always_ff @(posedge clk_sys)
			begin
				if (anyReset)
					powerdown_select[i*2 +: 2] <= PD_NORMAL; // see [R11] see [R14]
				else if (cmd == CMD_GC_WAKE)
					powerdown_select[i*2 +: 2] <= PD_NORMAL; // see [R19] see [R14]
				else if (pdCommand(cmd) && cmdChanMask[i] && cmdPdValid)
					powerdown_select[i*2 +: 2] <= cmdPd; // see [R8] see [R12] see [R13]
			end

			// Reference and gain; gain of two refused with the supply as reference.
			always_ff @(posedge clk_sys)
			begin
				if (anyReset)
				begin
					reference_select[i*2 +: 2] <= REF_RST;
					gain_select[i]             <= 1'b0;
				end
				else if (wrCommand(cmd) && cmdChanMask[i] && cmdCfgValid)
				begin
					reference_select[i*2 +: 2] <= cmdRef;
					gain_select[i]             <= cmdGain && (cmdRef != REF_VDD); // see [R18]
				end
			end

			assign chIf.rst   = anyReset;
			assign chIf.pdSel = powerdown_select[i*2 +: 2];
			assign seqDrive[i]       = chIf.drive;
			assign seqAmp[i]         = chIf.ampOn;
			assign seqPull[i*2 +: 2] = chIf.pullSel;

			dlp_pd_seq #(
				.ENTRY_CYC (ENTRY_CYC),
				.EXIT_CYC  (EXIT_CYC)
			) u_seq (
				.clk_sys (clk_sys),
				.ch      (chIf.seq)
			);

			// Output stage controls registered so every output comes from a flop.
			always_ff @(posedge clk_sys)
			begin
				if (srst)
				begin
					ampEnable[i]         <= 1'b1;
					outDrive[i]          <= 1'b1;
					pullSelect[i*2 +: 2] <= PD_NORMAL;
				end
				else
				begin
					ampEnable[i]         <= seqAmp[i]; // see [R9] see [R15]
					outDrive[i]          <= seqDrive[i]; // see [R10] see [R16]
					pullSelect[i*2 +: 2] <= seqPull[i*2 +: 2]; // see [R7]
				end
			end

			property p_hold;
				@(posedge clk_sys) disable iff (anyReset)
				!latchOpen |=> $stable(wiper[i*CW +: CW]);
			endproperty
			a_hold: assert property (p_hold) else $error("wiper moved while blocked"); // see [R1]

			property p_follow;
				@(posedge clk_sys) disable iff (anyReset)
				latchOpen |=> (wiper[i*CW +: CW] == $past(codeReg[i*CW +: CW]));
			endproperty
			a_follow: assert property (p_follow) else $error("wiper did not follow"); // see [R2]

			property p_entry;
				@(posedge clk_sys) disable iff (anyReset)
				($rose(powerdown_select[i*2 +: 2] != PD_NORMAL) && outDrive[i]) |-> outDrive[i] [*8];
			endproperty
			a_entry: assert property (p_entry) else $error("drive released early"); // see [R10]

			property p_exit;
				@(posedge clk_sys) disable iff (anyReset)
				($fell(powerdown_select[i*2 +: 2] != PD_NORMAL) && !outDrive[i]) |-> !outDrive[i] [*8];
			endproperty
			a_exit: assert property (p_exit) else $error("drive restored early"); // see [R16]

			property p_wake;
				@(posedge clk_sys) disable iff (srst)
				(cmd == CMD_GC_WAKE) |=> (powerdown_select[i*2 +: 2] == PD_NORMAL);
			endproperty
			a_wake: assert property (p_wake) else $error("wake-up ignored"); // see [R19]

			property p_gain;
				@(posedge clk_sys) disable iff (srst)
				(reference_select[i*2 +: 2] == REF_VDD) |-> !gain_select[i];
			endproperty
			a_gain: assert property (p_gain) else $error("gain two with supply reference"); // see [R18]

			property p_pull;
				@(posedge clk_sys) disable iff (anyReset)
				outDrive[i] |-> (pullSelect[i*2 +: 2] == PD_NORMAL);
			endproperty
			a_pull: assert property (p_pull) else $error("pull-down while driving"); // see [R7]

			property p_gcrst;
				@(posedge clk_sys) disable iff (srst)
				(cmd == CMD_GC_RESET) |=> (codeReg[i*CW +: CW] == CW'(CODE_RST))
					&& (powerdown_select[i*2 +: 2] == PD_NORMAL);
			endproperty
			a_gcrst: assert property (p_gcrst) else $error("general-call reset incomplete"); // see [R17]

			// A powered-down stage must never have its amplifier on while a pull-down is engaged.
			property p_amp_pull;
				@(posedge clk_sys) disable iff (anyReset)
				(pullSelect[i*2 +: 2] != PD_NORMAL) |-> !ampEnable[i];
			endproperty
			a_amp_pull: assert property (p_amp_pull) else $error("amplifier on with pull-down"); // see [R9]

			// The open-output code must leave the pin undriven once the stage is off.
			property p_open_off;
				@(posedge clk_sys) disable iff (anyReset)
				(pullSelect[i*2 +: 2] == PD_OPEN) |-> !outDrive[i];
			endproperty
			a_open_off: assert property (p_open_off) else $error("open output still driven"); // see [R7]

			// With no command the code register keeps its value, powered down or not.
			property p_code_keep;
				@(posedge clk_sys) disable iff (anyReset)
				(cmd == CMD_NONE) |=> $stable(codeReg[i*CW +: CW]);
			endproperty
			a_code_keep: assert property (p_code_keep) else $error("code register changed idle"); // see [R9]

			// A write aimed at the other channel leaves this channel untouched.
			property p_mask;
				@(posedge clk_sys) disable iff (anyReset)
				(wrCommand(cmd) && !cmdChanMask[i]) |=> $stable(codeReg[i*CW +: CW]);
			endproperty
			a_mask: assert property (p_mask) else $error("unaddressed channel written"); // see [R8]

			// Only the listed commands may move the power-down field.
			property p_pd_keep;
				@(posedge clk_sys) disable iff (anyReset)
				!(pdCommand(cmd) || (cmd == CMD_GC_WAKE)) |=> $stable(powerdown_select[i*2 +: 2]);
			endproperty
			a_pd_keep: assert property (p_pd_keep) else $error("power-down field moved"); // see [R12]

			// A valid field in an addressed write or read is stored, including 00 to leave power-down.
			property p_pd_write;
				@(posedge clk_sys) disable iff (anyReset)
				(pdCommand(cmd) && cmdChanMask[i] && cmdPdValid) |=> (powerdown_select[i*2 +: 2] == $past(cmdPd));
			endproperty
			a_pd_write: assert property (p_pd_write) else $error("power-down field not stored"); // see [R14]

			// Configuration survives everything but a configuration write or a reset.
			property p_ref_keep;
				@(posedge clk_sys) disable iff (anyReset)
				!(wrCommand(cmd) && cmdCfgValid) |=> $stable(reference_select[i*2 +: 2]);
			endproperty
			a_ref_keep: assert property (p_ref_keep) else $error("reference select changed"); // see [R9]
		end
	endgenerate

	// Exposes the filtered latch level for observation.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			latchLevel <= 1'b0;
		else
			latchLevel <= latchOpen;
	end

	// The filter only moves when the two later stages agree, so a metastable first stage is never used.
	property p_latch_sync;
		@(posedge clk_sys) disable iff (srst)
		(holdSync[1] == holdSync[2]) |=> (latchOpen == !$past(holdSync[1]));
	endproperty
	a_latch_sync: assert property (p_latch_sync) else $error("latch filter out of step"); // see [R4]

	// The observed level trails the internal one by exactly one cycle.
	property p_level;
		@(posedge clk_sys) disable iff (srst)
		1'b1 |=> (latchLevel == $past(latchOpen));
	endproperty
	a_level: assert property (p_level) else $error("latch level output lags wrongly"); // see [R2]
endmodule

// >>> tb/dlp_master_model.sv
`timescale 1ns/1ps
// Stands in for the serial front end and the external latch strobe source.
module dlp_master_model
	import dlp_pkg::*;
(
	input  wire logic                    clk_sys,
	output dlp_pkg::dlp_cmd_t            cmd,
	output logic [dlp_pkg::CHANNELS-1:0] cmdChanMask,
	output logic                         cmdCodeValid,
	output logic [dlp_pkg::CODE_W-1:0]   cmdCode,
	output logic                         cmdPdValid,
	output logic [1:0]                   cmdPd,
	output logic                         cmdCfgValid,
	output logic [1:0]                   cmdRef,
	output logic                         cmdGain,
	output logic                         update_hold_n
);
	// Idle bus with the latch tied low, as a system without synchronised updates would.
	initial
	begin
		cmd = CMD_NONE;
		{cmdChanMask, cmdCodeValid, cmdCode, cmdPdValid, cmdPd, cmdCfgValid, cmdRef, cmdGain} = '0;
		update_hold_n = 1'b0;
	end

	// One command pulse; afterwards the fields are scrambled so that stale values cannot pass.
	task automatic issue(input dlp_cmd_t c, input logic [CHANNELS-1:0] m, input logic cv,
		input logic [CODE_W-1:0] code, input logic pv, input logic [1:0] pd,
		input logic fv, input logic [1:0] r, input logic g);
		@(posedge clk_sys);
		#1;
		cmd = c;
		cmdChanMask = m;
		{cmdCodeValid, cmdCode, cmdPdValid, cmdPd, cmdCfgValid, cmdRef, cmdGain} = {cv, code, pv, pd, fv, r, g};
		@(posedge clk_sys);
		#1;
		cmd = CMD_NONE;
		{cmdCodeValid, cmdPdValid, cmdCfgValid} = 3'h0;
		{cmdCode, cmdPd, cmdRef, cmdGain} = ~{cmdCode, cmdPd, cmdRef, cmdGain};
	endtask

	// The strobe is free of the command timing, so it may move in any cycle.
	task automatic setLatch(input logic v);
		@(posedge clk_sys);
		#1;
		update_hold_n = v;
	endtask
endmodule

// >>> tb/dlp_dac_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end
module dlp_dac_ctrl_tb;
	import dlp_pkg::*;
	logic        clk_sys;
	logic        srst;
	int          num_errors;
	int          compares;
	int          cycles;
	dlp_cmd_t    cmd;
	logic [1:0]  mask, pdIn, refIn, pdSel, refSel, ampEn, drv, gainSel;
	logic        cv, pv, fv, gain, latch, latchLevel;
	logic [11:0] code;
	logic [23:0] codeReg, wiper;
	logic [3:0]  pullSel;
	logic [3:0]  pdAll, refAll;

	// Shortened delays keep the power-down walks brief.
	dlp_dac_ctrl #(.ENTRY_CYC(10), .EXIT_CYC(10)) uut (.clk_sys(clk_sys), .srst(srst), .update_hold_n(latch),
		.cmd(cmd), .cmdChanMask(mask), .cmdCodeValid(cv), .cmdCode(code), .cmdPdValid(pv), .cmdPd(pdIn),
		.cmdCfgValid(fv), .cmdRef(refIn), .cmdGain(gain), .codeReg(codeReg), .wiper(wiper),
		.powerdown_select(pdAll), .reference_select(refAll), .gain_select(gainSel), .ampEnable(ampEn),
		.outDrive(drv), .pullSelect(pullSel), .latchLevel(latchLevel));
	dlp_master_model m (.clk_sys(clk_sys), .cmd(cmd), .cmdChanMask(mask), .cmdCodeValid(cv), .cmdCode(code),
		.cmdPdValid(pv), .cmdPd(pdIn), .cmdCfgValid(fv), .cmdRef(refIn), .cmdGain(gain), .update_hold_n(latch));

	// Clock at 50 MHz.
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Sampling lands after the drive offset so updates of the edge have settled.
	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask

	task automatic summarize;
		if (num_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// A hung wait must still end in the report.
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			summarize();
		end
	end

	task automatic t_reset;
		`CHK({codeReg, wiper, pdAll}, {48'h7ff7ff7ff7ff, 4'h0})
		`CHK({ampEn, drv, pullSel, gainSel}, {2'h3, 2'h3, 4'h0, 2'h0})
	endtask

	// Latch open: the wiper follows a write without any strobe edge.
	task automatic t_follow;
		waitc(6);
		m.issue(CMD_WRITE, 2'h1, 1'b1, 12'habc, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0);
		waitc(2);
		`CHK(wiper[11:0], 12'habc)
		`CHK(latchLevel, 1'b1)
	endtask

	// Latch closed: both registers load, wipers wait, then move in the same cycle.
	task automatic t_hold;
		m.setLatch(1'b1);
		waitc(6);
		m.issue(CMD_WRITE, 2'h1, 1'b1, 12'h123, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0);
		m.issue(CMD_WRITE, 2'h2, 1'b1, 12'h456, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0);
		waitc(4);
		`CHK(codeReg, 24'h456123)
		`CHK(wiper, 24'h7ffabc)
		`CHK(latchLevel, 1'b0)
		m.setLatch(1'b0);
		repeat (8)
		begin
			waitc(1);
			`CHK(wiper[11:0] == 12'h123, wiper[23:12] == 12'h456)
		end
		`CHK(wiper, 24'h456123)
		`CHK(latchLevel, 1'b1)
	endtask

	// Every power-down code on channel 1 only, with entry and exit delays.
	task automatic t_pd;
		logic [1:0] k;
		for (int i = 1; i < 4; i++)
		begin
			k = i[1:0];
			m.issue(CMD_WRITE, 2'h2, 1'b0, 12'h0, 1'b1, k, 1'b0, 2'h0, 1'b0);
			`CHK(pdAll, {k, 2'h0})
			waitc(3);
			`CHK(drv, 2'h3)
			waitc(15);
			`CHK({drv, ampEn, pullSel}, {2'h1, 2'h1, k, 2'h0})
			`CHK(codeReg, 24'h456123)
			m.issue(CMD_WRITE, 2'h2, 1'b0, 12'h0, 1'b1, 2'h0, 1'b0, 2'h0, 1'b0);
			waitc(4);
			`CHK(drv[1], 1'b0)
			waitc(15);
			`CHK({drv, ampEn, pullSel}, {2'h3, 2'h3, 4'h0})
		end
	endtask

	// Read, wake-up, gain refusal and general-call reset.
	task automatic t_cmds;
		m.issue(CMD_READ_HV, 2'h3, 1'b0, 12'h0, 1'b1, 2'h2, 1'b0, 2'h0, 1'b0);
		`CHK(pdAll, 4'ha)
		waitc(15);
		m.issue(CMD_WRITE_HV, 2'h1, 1'b1, 12'h321, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0);
		`CHK({codeReg[11:0], drv}, {12'h321, 2'h0})
		m.issue(CMD_GC_WAKE, 2'h0, 1'b0, 12'h0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0);
		`CHK(pdAll, 4'h0)
		m.issue(CMD_READ, 2'h1, 1'b0, 12'h0, 1'b1, 2'h3, 1'b0, 2'h0, 1'b0);
		`CHK(pdAll, 4'h3)
		m.issue(CMD_WRITE, 2'h1, 1'b0, 12'h0, 1'b0, 2'h0, 1'b1, REF_VDD, 1'b1);
		`CHK(gainSel[0], 1'b0)
		m.issue(CMD_WRITE, 2'h1, 1'b0, 12'h0, 1'b0, 2'h0, 1'b1, REF_BG, 1'b1);
		`CHK({refAll[1:0], gainSel[0]}, {REF_BG, 1'b1})
		m.issue(CMD_GC_RESET, 2'h0, 1'b0, 12'h0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0);
		`CHK({codeReg, pdAll, refAll, gainSel}, {24'h7ff7ff, 4'h0, 4'h0, 2'h0})
	endtask

	initial
	begin
		num_errors = 0;
		compares = 0;
		cycles = 0;
		srst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		srst = 1'b0;
		waitc(1);
		t_reset();
		t_follow();
		t_hold();
		t_pd();
		t_cmds();
		summarize();
	end
endmodule
